/* wdg_regs.svh */
// Purpose: Constants for the watchdog command parser
// Assumes: Included by bare name from the design files
// Notes: Characters are ASCII; masks and timeout reset values
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_CH_START 8'h24
`define WDG_CH_CR 8'h0D
`define WDG_CH_ACK 8'h21
`define WDG_CH_NAK 8'h3F
`define WDG_CH_X 8'h58
`define WDG_CH_R 8'h52
`define WDG_CH_E 8'h45
`define WDG_CH_W 8'h57
`define WDG_CH_S 8'h53
`define WDG_CH_D 8'h44
`define WDG_CH_ZERO 8'h30

`define WDG_LEN_SET_TO 4'h7
`define WDG_LEN_GET_TO 4'h4
`define WDG_LEN_SET_SLOT 4'h7
`define WDG_LEN_GET_SLOT 4'h5
`define WDG_LEN_SET_CHAN 4'hA
`define WDG_LEN_GET_CHAN 4'h5
`define WDG_LEN_ADDR 4'h3
`define WDG_LEN_MAX 4'hA

`define WDG_RSP_SHORT 4'h4
`define WDG_RSP_SLOT 4'h6
`define WDG_RSP_LONG 4'h8

`define WDG_SLOTS 4'h8
`define WDG_TIMEOUT_RST 16'h0000
`define WDG_SLOT_MASK_RST 8'h00
`define WDG_CHAN_MASK_RST 16'hFFFF

`endif

/* wdg_pkg.sv */
// Purpose: Shared types for the watchdog command parser
// Assumes: One-hot state encoding
// Notes: Constants live in wdg_regs.svh
package wdg_pkg;
  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_LOOK = 3'b010,
    ST_TX = 3'b100
  } wdg_state_t;
endpackage

/* wdg_mask_mem.sv */
// Purpose: Per-slot channel enable masks, one write and two read ports
// Assumes: Single clock, reads return data one cycle after the address
// Notes: Small enough to live in flops so it can reset to a known mask
`timescale 1ns/1ps
`include "wdg_regs.svh"
module wdg_mask_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddrA,
  output logic [WIDTH-1:0] rdDataA_q,
  input wire logic [AW-1:0] rdAddrB,
  output logic [WIDTH-1:0] rdDataB_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];

  // Next contents: only the addressed word changes
  always_comb begin
    mem_d = mem_q;
    if (wrEn) begin
      mem_d[wrAddr] = wrData;
    end
  end

  // Storage and registered read data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= WIDTH'(`WDG_CHAN_MASK_RST);
      end
      rdDataA_q <= WIDTH'(`WDG_CHAN_MASK_RST);
      rdDataB_q <= WIDTH'(`WDG_CHAN_MASK_RST);
    end else begin
      mem_q <= mem_d;
      rdDataA_q <= mem_q[rdAddrA];
      rdDataB_q <= mem_q[rdAddrB];
    end
  end
endmodule

/* wdg_cmd_parser.sv */
// Purpose: ASCII command parser configuring the watchdog guard
// Assumes: Byte stream and devAddr come from logic on mclk
// Notes: Bytes arriving while a reply is sent are dropped (rxReady_q low)
// Notes on behaviour
// [RULE1] Command $AAXdddd<cr> stores four decimal digits as timeout seconds.
// [RULE2] Set-timeout answers !AA<cr> on success, ?AA<cr> on failure.
// [RULE3] Command $AAXR<cr> answers !AA plus stored four timeout digits, <cr>.
// [RULE4] Command $AAXEWmm<cr> stores two-hex-digit slot mask, then acknowledges or refuses.
// [RULE5] Command $AAXER<cr> answers !AA plus slot mask as two hex digits.
// [RULE6] Command $AAXSiDmmmm<cr> gives a four-hex-digit channel mask for slot i.
// [RULE7] Each slot keeps its own channel mask; set answers !AA or ?AA.
// [RULE8] Command $AAXSi<cr> answers !AA plus that slot's four-hex-digit mask.
// [RULE9] Address is two hex digits; only frames for our address are acted on.
// [RULE10] Every frame ends with carriage return 0Dh, which closes the frame.
// [RULE11] Syntax error, link error or foreign address gets no reply at all. The code answers ?AA to an unknown command after a good address and X.
// [RULE12] Set mask bits enable slot or channel watchdog action; clear bits exclude.
`timescale 1ns/1ps
`include "wdg_regs.svh"
module wdg_cmd_parser #(
  parameter int SLOT_AW = 3,
  parameter int CHAN_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] devAddr,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxError,
  output logic rxReady_q,
  output logic txValid_q,
  output logic [7:0] txByte_q,
  input wire logic txReady,
  output logic [15:0] timeoutSecs_q,
  output logic [7:0] slotEnable_q,
  input wire logic [SLOT_AW-1:0] chanSel,
  output logic [CHAN_W-1:0] chanEnable_q
);
  wdg_pkg::wdg_state_t state_q, state_d;
  logic [7:0] buf_q [10];
  logic [7:0] buf_d [10];
  logic [7:0] rsp_q [8];
  logic [7:0] rsp_d [8];
  logic [3:0] len_q, len_d, rspLen_q, rspLen_d;
  logic [2:0] idx_q, idx_d;
  logic armed_q, armed_d, bad_q, bad_d;
  logic txValid_d, rxReady_d;
  logic [7:0] txByte_d, slotEnable_d;
  logic [15:0] timeoutSecs_d;
  logic frameEnd, addrOk, slotOk, memWe;
  logic cmdSetTo, cmdGetTo, cmdSetSlot, cmdGetSlot, cmdSetChan, cmdGetChan;
  logic [15:0] newTimeout, newChan;
  logic [7:0] newSlot;
  logic [CHAN_W-1:0] memRd;
  logic [3:0] slotNib;

  function automatic logic isHex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
  endfunction

  function automatic logic isDec(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction

  function automatic logic [3:0] hexVal(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
  endfunction

  function automatic logic [7:0] toAsc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // Frame decode, valid in the cycle the carriage return arrives
  assign frameEnd = state_q == wdg_pkg::ST_RX && rxValid && rxByte == `WDG_CH_CR
    && armed_q && !bad_q && !rxError; // RULE10
  assign addrOk = len_q >= `WDG_LEN_ADDR && isHex(buf_q[0]) && isHex(buf_q[1])
    && {hexVal(buf_q[0]), hexVal(buf_q[1])} == devAddr && buf_q[2] == `WDG_CH_X; // RULE9
  assign cmdSetTo = len_q == `WDG_LEN_SET_TO && isDec(buf_q[3]) && isDec(buf_q[4])
    && isDec(buf_q[5]) && isDec(buf_q[6]); // RULE1
  assign cmdGetTo = len_q == `WDG_LEN_GET_TO && buf_q[3] == `WDG_CH_R;
  assign cmdSetSlot = len_q == `WDG_LEN_SET_SLOT && buf_q[3] == `WDG_CH_E && buf_q[4] == `WDG_CH_W
    && isHex(buf_q[5]) && isHex(buf_q[6]); // RULE4
  assign cmdGetSlot = len_q == `WDG_LEN_GET_SLOT && buf_q[3] == `WDG_CH_E && buf_q[4] == `WDG_CH_R;
  assign cmdSetChan = len_q == `WDG_LEN_SET_CHAN && buf_q[3] == `WDG_CH_S && isHex(buf_q[4])
    && buf_q[5] == `WDG_CH_D && isHex(buf_q[6]) && isHex(buf_q[7])
    && isHex(buf_q[8]) && isHex(buf_q[9]); // RULE6
  assign cmdGetChan = len_q == `WDG_LEN_GET_CHAN && buf_q[3] == `WDG_CH_S && isHex(buf_q[4]);
  assign slotNib = hexVal(buf_q[4]);
  assign slotOk = slotNib < `WDG_SLOTS;
  assign newTimeout = {buf_q[3][3:0], buf_q[4][3:0], buf_q[5][3:0], buf_q[6][3:0]};
  assign newSlot = {hexVal(buf_q[5]), hexVal(buf_q[6])};
  assign newChan = {hexVal(buf_q[6]), hexVal(buf_q[7]), hexVal(buf_q[8]), hexVal(buf_q[9])};
  assign memWe = frameEnd && addrOk && cmdSetChan && slotOk; // RULE7

  // Channel masks per slot; port B feeds the watchdog guard
  wdg_mask_mem #(
    .DEPTH(1 << SLOT_AW),
    .WIDTH(CHAN_W),
    .AW(SLOT_AW)
  ) maskMem (
    .mclk(mclk),
    .rstn(rstn),
    .wrEn(memWe),
    .wrAddr(slotNib[SLOT_AW-1:0]),
    .wrData(newChan[CHAN_W-1:0]),
    .rdAddrA(slotNib[SLOT_AW-1:0]),
    .rdDataA_q(memRd),
    .rdAddrB(chanSel),
    .rdDataB_q(chanEnable_q) // RULE12
  );

  // Collect, decode, build and send replies
  always_comb begin
    state_d = state_q;
    buf_d = buf_q;
    rsp_d = rsp_q;
    len_d = len_q;
    rspLen_d = rspLen_q;
    idx_d = idx_q;
    armed_d = armed_q;
    bad_d = bad_q;
    txValid_d = txValid_q;
    txByte_d = txByte_q;
    timeoutSecs_d = timeoutSecs_q;
    slotEnable_d = slotEnable_q;
    case (state_q)
      wdg_pkg::ST_RX: begin
        if (rxValid && rxByte == `WDG_CH_START) begin
          armed_d = 1'b1;
          bad_d = rxError;
          len_d = 4'h0;
        end else if (rxValid && armed_q && rxByte == `WDG_CH_CR) begin
          armed_d = 1'b0;
          // Silent drop unless addressed to us and clean
          if (frameEnd && addrOk) begin // RULE11
            rsp_d[0] = `WDG_CH_NAK;
            rsp_d[1] = toAsc(devAddr[7:4]);
            rsp_d[2] = toAsc(devAddr[3:0]);
            rsp_d[3] = `WDG_CH_CR;
            rspLen_d = `WDG_RSP_SHORT;
            idx_d = 3'h0;
            state_d = wdg_pkg::ST_TX;
            if (cmdSetTo) begin
              timeoutSecs_d = newTimeout; // RULE1
              rsp_d[0] = `WDG_CH_ACK; // RULE2
            end else if (cmdGetTo) begin
              rsp_d[0] = `WDG_CH_ACK; // RULE3
              for (int i = 0; i < 4; i++) begin
                rsp_d[3 + i] = toAsc(timeoutSecs_q[15 - 4 * i -: 4]);
              end
              rsp_d[7] = `WDG_CH_CR;
              rspLen_d = `WDG_RSP_LONG;
            end else if (cmdSetSlot) begin
              slotEnable_d = newSlot; // RULE4
              rsp_d[0] = `WDG_CH_ACK;
            end else if (cmdGetSlot) begin
              rsp_d[0] = `WDG_CH_ACK; // RULE5
              rsp_d[3] = toAsc(slotEnable_q[7:4]);
              rsp_d[4] = toAsc(slotEnable_q[3:0]);
              rsp_d[5] = `WDG_CH_CR;
              rspLen_d = `WDG_RSP_SLOT;
            end else if (cmdSetChan && slotOk) begin
              rsp_d[0] = `WDG_CH_ACK; // RULE7
            end else if (cmdGetChan && slotOk) begin
              rsp_d[0] = `WDG_CH_ACK; // RULE8
              state_d = wdg_pkg::ST_LOOK;
            end
            txValid_d = state_d == wdg_pkg::ST_TX;
            txByte_d = rsp_d[0];
          end
        end else if (rxValid && armed_q) begin
          // Overlong frames are spoiled until the next start character
          if (rxError || len_q == `WDG_LEN_MAX) begin
            bad_d = 1'b1;
          end else begin
            buf_d[len_q] = rxByte;
            len_d = len_q + 4'h1;
          end
        end
      end
      wdg_pkg::ST_LOOK: begin
        for (int i = 0; i < 4; i++) begin
          rsp_d[3 + i] = toAsc(memRd[15 - 4 * i -: 4]); // RULE8
        end
        rsp_d[7] = `WDG_CH_CR;
        rspLen_d = `WDG_RSP_LONG;
        txValid_d = 1'b1;
        txByte_d = rsp_q[0];
        state_d = wdg_pkg::ST_TX;
      end
      wdg_pkg::ST_TX: begin
        if (txReady) begin
          if ({1'b0, idx_q} + 4'h1 == rspLen_q) begin
            txValid_d = 1'b0;
            state_d = wdg_pkg::ST_RX;
          end else begin
            idx_d = idx_q + 3'h1;
            txByte_d = rsp_q[idx_q + 3'h1];
          end
        end
      end
      default: begin
        state_d = wdg_pkg::ST_RX;
        txValid_d = 1'b0;
      end
    endcase
    rxReady_d = state_d == wdg_pkg::ST_RX;
  end

  // Register stage for parser state and outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= wdg_pkg::ST_RX;
      for (int i = 0; i < 10; i++) begin
        buf_q[i] <= 8'h00;
      end
      for (int i = 0; i < 8; i++) begin
        rsp_q[i] <= 8'h00;
      end
      len_q <= 4'h0;
      rspLen_q <= 4'h0;
      idx_q <= 3'h0;
      armed_q <= 1'b0;
      bad_q <= 1'b0;
      txValid_q <= 1'b0;
      txByte_q <= 8'h00;
      rxReady_q <= 1'b0;
      timeoutSecs_q <= `WDG_TIMEOUT_RST;
      slotEnable_q <= `WDG_SLOT_MASK_RST;
    end else begin
      state_q <= state_d;
      buf_q <= buf_d;
      rsp_q <= rsp_d;
      len_q <= len_d;
      rspLen_q <= rspLen_d;
      idx_q <= idx_d;
      armed_q <= armed_d;
      bad_q <= bad_d;
      txValid_q <= txValid_d;
      txByte_q <= txByte_d;
      rxReady_q <= rxReady_d;
      timeoutSecs_q <= timeoutSecs_d;
      slotEnable_q <= slotEnable_d;
    end
  end

  // Checks on stored values and reply framing
  timeout_store_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
    frameEnd && addrOk && cmdSetTo |=> timeoutSecs_q == $past(newTimeout) && txByte_q == `WDG_CH_ACK)
    else $error("timeout not stored or not acknowledged");
  reply_start_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE2
    $rose(txValid_q) |-> txByte_q == `WDG_CH_ACK || txByte_q == `WDG_CH_NAK)
    else $error("reply does not start with ack or refusal");
  get_timeout_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
    frameEnd && addrOk && cmdGetTo |=> txValid_q && rspLen_q == `WDG_RSP_LONG)
    else $error("timeout read reply has wrong length");
  slot_store_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
    frameEnd && addrOk && cmdSetSlot |=> slotEnable_q == $past(newSlot))
    else $error("slot mask not stored");
  get_slot_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE5
    frameEnd && addrOk && cmdGetSlot |=> rspLen_q == `WDG_RSP_SLOT && rsp_q[5] == `WDG_CH_CR)
    else $error("slot read reply malformed");
  chan_write_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE7
    frameEnd && addrOk && cmdSetChan && !slotOk |-> !memWe ##1 txByte_q == `WDG_CH_NAK)
    else $error("bad slot not refused");
  chan_read_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE8
    frameEnd && addrOk && cmdGetChan && slotOk |=> state_q == wdg_pkg::ST_LOOK && !txValid_q ##1 txValid_q)
    else $error("channel read lookup sequence wrong");
  foreign_drop_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
    frameEnd && !addrOk |=> !txValid_q [*2])
    else $error("reply sent for foreign address");
  frame_end_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE10
    txValid_q && txReady && {1'b0, idx_q} + 4'h1 == rspLen_q |-> txByte_q == `WDG_CH_CR ##1 !txValid_q)
    else $error("reply not closed by carriage return");
  silent_rx_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
    state_q == wdg_pkg::ST_RX |-> !txValid_q)
    else $error("transmit while collecting a frame");
  mask_change_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
    $changed(slotEnable_q) |-> $past(frameEnd && addrOk && cmdSetSlot))
    else $error("slot enables changed without a command");
endmodule

/* wdg_host_model.sv */
// Purpose: Remote host model that sends command frames and collects replies
// Assumes: Bytes go out at falling edges of mclk, one per cycle
// Notes: slow makes txReady stall every other cycle to stretch replies
`timescale 1ns/1ps
module wdg_host_model (
  input wire logic mclk,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxError,
  output logic txReady
);
  string reply = "";
  bit slow = 0;
  logic [7:0] lastByte = 8'h00;

  // Idle line shows a non-ASCII pattern, never a stale byte
  initial begin
    rxValid = 1'b0;
    rxByte = 8'hFF;
    rxError = 1'b0;
    txReady = 1'b0;
  end

  // Frame is the string as given, start char and address included, then carriage return
  task automatic send(input string s, input int errAt);
    for (int i = 0; i <= s.len(); i++) begin
      @(negedge mclk);
      rxValid = 1'b1;
      rxByte = (i == s.len()) ? 8'h0D : s[i];
      rxError = (i == errAt);
      lastByte = rxByte;
    end
    @(negedge mclk);
    rxValid = 1'b0;
    rxError = 1'b0;
    rxByte = ~lastByte;  // Released line must not look like the last byte
  endtask

  // Stall pattern changes off the sampling edge
  always @(negedge mclk) begin
    txReady <= slow ? ~txReady : 1'b1;
  end

  // Reply byte is taken on the edge where valid and ready meet
  always @(posedge mclk) begin
    if (txValid && txReady) begin
      reply = $sformatf("%s%c", reply, txByte);
    end
  end
endmodule

/* wdg_cmd_parser_tb.sv */
// Purpose: Self-checking bench for the watchdog command parser
// Assumes: Host model drives the byte stream; devAddr set by the bench
// Notes: Each scenario task after t_reset sends frames and judges replies and outputs; t_reset only checks reset outputs
`timescale 1ns/1ps
module wdg_cmd_parser_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] devAddr = 8'h01;
  logic [2:0] chanSel = 3'h0;
  logic rxValid;
  logic [7:0] rxByte;
  logic rxError;
  logic rxReady_q;
  logic txValid_q;
  logic [7:0] txByte_q;
  logic txReady;
  logic [15:0] timeoutSecs_q;
  logic [7:0] slotEnable_q;
  logic [15:0] chanEnable_q;
  int errCount = 0;
  int nTests = 0;

  always #12.5 mclk = ~mclk;

  wdg_cmd_parser uut (.mclk(mclk), .rstn(rstn), .devAddr(devAddr), .rxValid(rxValid), .rxByte(rxByte),
    .rxError(rxError), .rxReady_q(rxReady_q), .txValid_q(txValid_q), .txByte_q(txByte_q), .txReady(txReady),
    .timeoutSecs_q(timeoutSecs_q), .slotEnable_q(slotEnable_q), .chanSel(chanSel), .chanEnable_q(chanEnable_q));

  wdg_host_model host (.mclk(mclk), .txValid(txValid_q), .txByte(txByte_q), .rxValid(rxValid), .rxByte(rxByte),
    .rxError(rxError), .txReady(txReady));

  task automatic reportAndStop;
    if (errCount == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_str(input string name, input string exp, input string got);
    nTests++;
    if (exp != got) begin
      errCount++;
      $display("unexpected %s: expected '%s' seen '%s'", name, exp, got);
    end
  endtask

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Sends one frame, waits for a closing CR under a bound, then checks ready
  task automatic run(input string cmd, input int errAt, input string exp);
    int n;
    bit busyReady;
    host.reply = "";
    host.send(cmd, errAt);
    n = 0;
    busyReady = 1'b0;
    while (n < 80 && (host.reply.len() == 0 || host.reply[host.reply.len() - 1] != 8'h0D)) begin
      @(negedge mclk);
      // Parser must not claim to take bytes while a reply is pending
      if ((txValid_q & rxReady_q) !== 1'b0) begin
        busyReady = 1'b1;
      end
      n++;
    end
    chk_str(cmd, exp, host.reply);
    chk_val("rxReady_q busy", 16'h0000, {15'h0000, busyReady});
    repeat (3) @(negedge mclk);
    chk_val("rxReady_q", 16'h0001, {15'h0000, rxReady_q});
  endtask

  // Mask of one slot, seen two cycles after the select
  task automatic chk_chan(input logic [2:0] slot, input logic [15:0] exp);
    chanSel = slot;
    repeat (2) @(negedge mclk);
    chk_val("chanEnable_q", exp, chanEnable_q);
  endtask

  task automatic t_reset;
    chk_val("timeoutSecs_q", 16'h0000, timeoutSecs_q);
    chk_val("slotEnable_q", 16'h0000, {8'h00, slotEnable_q});
    chk_val("txValid_q", 16'h0000, {15'h0000, txValid_q});
    chk_val("rxReady_q", 16'h0001, {15'h0000, rxReady_q});
    chk_chan(3'h5, 16'hFFFF);
  endtask

  // Store, read back, then a bad digit leaves the value alone; replies stall for the first store and read back
  task automatic t_timeout;
    host.slow = 1;
    run("$01X1234", -1, "!01\015");
    chk_val("timeoutSecs_q", 16'h1234, timeoutSecs_q);
    run("$01XR", -1, "!011234\015");
    host.slow = 0;
    run("$01X12A4", -1, "?01\015");
    chk_val("timeoutSecs_q", 16'h1234, timeoutSecs_q);
    run("$01X9999", -1, "!01\015");
    run("$01XR", -1, "!019999\015");
  endtask

  task automatic t_slot;
    run("$01XEWA5", -1, "!01\015");
    chk_val("slotEnable_q", 16'h00A5, {8'h00, slotEnable_q});
    run("$01XER", -1, "!01A5\015");
    run("$01XEW5", -1, "?01\015");
    chk_val("slotEnable_q", 16'h00A5, {8'h00, slotEnable_q});
  endtask

  // Two slots written, a third left at its reset mask, slot 8 refused
  task automatic t_chan;
    run("$01XS3D0F0F", -1, "!01\015");
    run("$01XS7DC001", -1, "!01\015");
    chk_chan(3'h3, 16'h0F0F);
    chk_chan(3'h7, 16'hC001);
    chk_chan(3'h2, 16'hFFFF);
    run("$01XS3", -1, "!010F0F\015");
    run("$01XS7", -1, "!01C001\015");
    run("$01XS8D1111", -1, "?01\015");
    run("$01XS9", -1, "?01\015");
  endtask

  // Faulty or foreign frames stay silent and change nothing
  task automatic t_silent;
    run("$02X0001", -1, "");
    run("$01X0002", 4, "");
    run("$01Y0003", -1, "");
    run("$0GXR", -1, "");
    run("$01XS3D0000000", -1, "");
    run("Z\015$01XER", -1, "!01A5\015");
    chk_val("timeoutSecs_q", 16'h9999, timeoutSecs_q);
  endtask

  // Own address high in the range, given in lower case for AB and upper case for FF
  task automatic t_addr;
    devAddr = 8'hAB;
    repeat (2) @(negedge mclk);
    run("$abXR", -1, "!AB9999\015");
    run("$01XR", -1, "");
    devAddr = 8'hFF;
    repeat (2) @(negedge mclk);
    run("$FFXER", -1, "!FFA5\015");
  endtask

  // Bound on the whole run, far above the expected thousand or so cycles
  initial begin
    #500000;
    errCount++;
    reportAndStop();
  end

  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset();
    t_timeout();
    t_slot();
    t_chan();
    t_silent();
    t_addr();
    reportAndStop();
  end
endmodule
